//--- bstp_pkg.sv
/*
  Constants, state encoding and instruction codes of the boundary-scan
  test port. Assumes a single 100 MHz system clock that samples the
  slow test clock and test inputs through synchronisers.
*/
// Summary of operation
// RL1 - Mode-select and data in are sampled on rising test-clock edges.
// RL2 - Serial data out changes only on falling test-clock edges.
// RL3 - Unconnected mode-select and data in read high through pull-ups.
// RL4 - Data enters at the MSB; data out is taken from the LSB.
// RL5 - The held instruction picks the data register in the path.
// RL6 - Only one scan register sits in the serial path at once.
// RL7 - Data out is driven only in shift states, else high impedance.
// RL8 - Five rising edges with mode-select high reset the test logic.
// RL9 - Power-up reset leaves serial data out at high impedance.
// RL10 - Instruction register is three bits, loaded serially in path.
// RL11 - Instruction register holds the ID instruction after any reset.
// RL12 - Capture-instruction loads binary 01 into the two low bits.
// RL13 - Shifted instruction takes effect only at update-instruction.
// RL14 - Eight codes decode; three reserved ones are left unimplemented.
// RL15 - Bypass is one bit, cleared low when bypass is executed.
// RL16 - Capture-data loads the pin ring; shift-data shifts it.
// RL17 - Ring capture works under external, sample and hi-Z-sample.
// RL18 - Chain has cells for unconnected pins, one cell per bump.
// RL19 - ID instruction captures a hardwired 32-bit code at capture-data.
// RL20 - ID instruction puts the ID register in the path for shifting.
// RL21 - Hi-Z-sample shifts the ring and floats the output bus.
// RL22 - Under external test, cell 108 enables the output bus drivers.
// RL23 - Controller is the standard sixteen-state scan state machine.
// RL24 - Instruction encodings are named constants, freely chosen.
package bstp_pkg;

  // Register widths
  localparam int unsigned BSTP_IR_W    = 3;
  localparam int unsigned BSTP_ID_W    = 32;
  localparam int unsigned BSTP_BSR_LEN = 110; // Includes spare NC cells
  localparam int unsigned BSTP_OE_CELL = 108; // Output bus control cell

  // Instruction encodings, eight codes in all [RL24]
  localparam logic [2:0] BSTP_I_EXTEST = 3'h0;
  localparam logic [2:0] BSTP_I_IDCODE = 3'h1;
  localparam logic [2:0] BSTP_I_SAMPZ  = 3'h2;
  localparam logic [2:0] BSTP_I_RSV3   = 3'h3;
  localparam logic [2:0] BSTP_I_SAMPLE = 3'h4;
  localparam logic [2:0] BSTP_I_RSV5   = 3'h5;
  localparam logic [2:0] BSTP_I_RSV6   = 3'h6;
  localparam logic [2:0] BSTP_I_BYPASS = 3'h7;

  // Capture-IR pattern, low two bits are 01
  localparam logic [2:0] BSTP_IR_CAP = 3'h1;

  // Identification code; value is arbitrary, bit 0 set as usual
  localparam logic [31:0] BSTP_IDCODE = 32'h0ABC_D001;

  // Synchroniser reset levels: clock low, pulled-up pins high
  localparam logic BSTP_TCK_RST = 1'h0;
  localparam logic BSTP_PIN_RST = 1'h1;

  // Controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR,
    ST_UPD_IR
  } bstp_state_e;

endpackage

//--- bstp_sync.sv
/*
  Three-stage synchroniser with agreement filter for slow pin inputs.
  Assumes the inputs come from outside the system clock domain.
*/
`timescale 1ns/1ns
module bstp_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,  // System clock
  input  wire logic         rst,  // Synchronous reset, active high
  input  wire logic [W-1:0] din,  // Asynchronous pin levels
  output logic      [W-1:0] lvl   // Filtered, settled levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } bstp_sync_s;

  bstp_sync_s r_q, r_d;

  // Stage one feeds only stage two; the filter sees stages two and three
  always_comb
  begin
    r_d    = r_q;
    r_d.s1 = din;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (r_q.s2[i] == r_q.s3[i])
      begin
        r_d.lvl[i] = r_q.s3[i]; // Change counts once both agree
      end
    end
  end

  // Reset to idle levels so no false edge appears at release
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign lvl = r_q.lvl;

endmodule // bstp_sync

//--- bstp_shreg.sv
/*
  Capture-and-shift scan register used for instruction, identification
  and boundary chains. Assumes capture and shift are one-cycle strobes
  that are never high together.
*/
`timescale 1ns/1ns
module bstp_shreg #(
  parameter int unsigned  W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst,      // Synchronous reset, active high
  input  wire logic         cap,      // Parallel capture strobe
  input  wire logic         shift,    // Shift-one-place strobe
  input  wire logic         si,       // Serial input
  input  wire logic [W-1:0] cap_val,  // Value loaded on capture
  output logic      [W-1:0] data      // Register contents, LSB is out
);

  typedef struct packed {
    logic [W-1:0] data;
  } bstp_shreg_s;

  bstp_shreg_s r_q, r_d;

  // Shift moves toward the LSB, new bit enters at the MSB
  always_comb
  begin
    r_d = r_q;
    if (cap)
    begin
      r_d.data = cap_val;
    end
    else if (shift)
    begin
      r_d.data = {si, r_q.data[W-1:1]}; // [RL4]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_q.data <= RST_VAL;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign data = r_q.data;

endmodule // bstp_shreg

//--- bstp_top.sv
/*
  Boundary-scan test port: sixteen-state controller, instruction,
  bypass, identification and boundary registers, serial output and
  output-bus control for the memory. Assumes the test clock is a slow
  pin sampled by the 100 MHz system clock (at least four system cycles
  per test-clock phase), and that the pad ring resolves tdo from
  tdo_oe and provides pull-ups on the mode-select and data-in pins.
  Pin edges reach the logic about four system cycles late; tms and
  tdi pass the same filter, so their timing against tck still holds.
  The boundary chain captures ring_in as presented; keeping it
  settled around capture is up to the surrounding logic.
*/
`timescale 1ns/1ns
module bstp_top
  import bstp_pkg::*;
(
  input  wire logic                            clk,      // 100 MHz clock
  input  wire logic                            rst,      // Power-up reset
  input  wire logic                            tck,      // Test clock pin
  input  wire logic                            tms,      // Mode-select pin
  input  wire logic                            tdi,      // Serial data in
  input  wire logic [bstp_pkg::BSTP_BSR_LEN-1:0] ring_in,  // Pin ring
  output logic                                 tdo,      // Serial data out
  output logic                                 tdo_oe,   // Drive tdo
  output logic                                 q_bus_en, // Memory Q drive
  output logic                                 extest_on,// External test
  output logic [bstp_pkg::BSTP_BSR_LEN-1:0]      ring_out  // Preload cells
);

  import bstp_pkg::*;

  // All state in one record, registered in one place
  typedef struct packed {
    logic                    tck_prev;
    bstp_state_e             st;
    logic [BSTP_IR_W-1:0]    instr;
    logic                    byp;
    logic                    tdo;
    logic                    tdo_oe;
    logic [BSTP_BSR_LEN-1:0] upd;
    logic                    q_en;
    logic                    extest;
  } bstp_top_s;

  bstp_top_s r_q, r_d;

  // Settled pins, edge strobes and register taps
  logic                    tck_s;
  logic                    tms_s;
  logic                    tdi_s;
  logic                    tck_rise;
  logic                    tck_fall;
  logic                    cap_ir;
  logic                    sh_ir;
  logic                    cap_dr;
  logic                    sh_dr;
  logic                    sel_id;
  logic                    sel_bsr;
  logic                    sel_byp;
  logic                    ser_out;
  logic [BSTP_IR_W-1:0]    ir_sh;
  logic [BSTP_ID_W-1:0]    id_sh;
  logic [BSTP_BSR_LEN-1:0] bsr_sh;

  // Pin inputs pass four flops; pulled-up pins rest high in reset
  bstp_sync #(
    .W       (3),
    .RST_VAL ({BSTP_TCK_RST, BSTP_PIN_RST, BSTP_PIN_RST}) // [RL3]
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .din ({tck, tms, tdi}),
    .lvl ({tck_s, tms_s, tdi_s})
  );

  // Test-clock edges found from the settled level
  // A pin glitch shorter than one cycle never reaches here
  assign tck_rise = tck_s & ~r_q.tck_prev;
  assign tck_fall = ~tck_s & r_q.tck_prev;

  // Data register choice follows the held instruction only
  always_comb
  begin
    sel_id  = 1'b0;
    sel_bsr = 1'b0;
    sel_byp = 1'b0;
    case (r_q.instr) // [RL5]
      BSTP_I_IDCODE:
      begin
        sel_id = 1'b1; // [RL20]
      end
      BSTP_I_EXTEST, BSTP_I_SAMPLE, BSTP_I_SAMPZ:
      begin
        sel_bsr = 1'b1; // [RL17] [RL21]
      end
      BSTP_I_BYPASS, BSTP_I_RSV3, BSTP_I_RSV5, BSTP_I_RSV6:
      begin
        sel_byp = 1'b1; // Reserved codes fall back to bypass [RL14]
      end
      default:
      begin
        sel_byp = 1'b1;
      end
    endcase
  end

  // Capture and shift strobes, all on rising test-clock edges
  assign cap_ir = tck_rise & (r_q.st == ST_CAP_IR); // [RL12]
  assign sh_ir  = tck_rise & (r_q.st == ST_SH_IR);  // [RL10] [RL1]
  assign cap_dr = tck_rise & (r_q.st == ST_CAP_DR); // [RL16] [RL19]
  assign sh_dr  = tck_rise & (r_q.st == ST_SH_DR);  // [RL1]

  // Instruction shift stage, separate from the held instruction
  bstp_shreg #(
    .W       (BSTP_IR_W),
    .RST_VAL (BSTP_IR_CAP)
  ) u_ir (
    .clk     (clk),
    .rst     (rst),
    .cap     (cap_ir),
    .shift   (sh_ir),
    .si      (tdi_s),
    .cap_val (BSTP_IR_CAP), // [RL12]
    .data    (ir_sh)
  );

  // Identification register loads the hardwired code at capture
  bstp_shreg #(
    .W       (BSTP_ID_W),
    .RST_VAL (BSTP_IDCODE)
  ) u_id (
    .clk     (clk),
    .rst     (rst),
    .cap     (cap_dr & sel_id),
    .shift   (sh_dr & sel_id), // [RL6]
    .si      (tdi_s),
    .cap_val (BSTP_IDCODE), // [RL19]
    .data    (id_sh)
  );

  // Boundary chain; unconnected-bump cells are part of ring_in
  bstp_shreg #(
    .W       (BSTP_BSR_LEN),
    .RST_VAL ('0)
  ) u_bsr (
    .clk     (clk),
    .rst     (rst),
    .cap     (cap_dr & sel_bsr), // [RL16] [RL17]
    .shift   (sh_dr & sel_bsr),  // [RL6]
    .si      (tdi_s),
    .cap_val (ring_in), // [RL18]
    .data    (bsr_sh)
  );

  // Bit presented to the serial output, LSB of the chosen register
  // The instruction stage wins while the IR column is shifting
  always_comb
  begin
    if (r_q.st == ST_SH_IR)
    begin
      ser_out = ir_sh[0]; // [RL4]
    end
    else if (sel_id)
    begin
      ser_out = id_sh[0];
    end
    else if (sel_bsr)
    begin
      ser_out = bsr_sh[0];
    end
    else
    begin
      ser_out = r_q.byp;
    end
  end

  // Controller, bypass, serial output and update registers
  always_comb
  begin
    r_d          = r_q;
    // Previous settled level, for edge finding
    r_d.tck_prev = tck_s;

    if (tck_rise)
    begin
      // Standard sixteen-state walk; five high samples reach reset
      case (r_q.st) // [RL23] [RL8]
        ST_TLR:
        begin
          r_d.st = tms_s ? ST_TLR : ST_RTI;
        end
        ST_RTI:
        begin
          r_d.st = tms_s ? ST_SEL_DR : ST_RTI;
        end
        ST_SEL_DR:
        begin
          r_d.st = tms_s ? ST_SEL_IR : ST_CAP_DR;
        end
        ST_CAP_DR:
        begin
          r_d.st = tms_s ? ST_EX1_DR : ST_SH_DR;
        end
        ST_SH_DR:
        begin
          r_d.st = tms_s ? ST_EX1_DR : ST_SH_DR;
        end
        ST_EX1_DR:
        begin
          r_d.st = tms_s ? ST_UPD_DR : ST_PA_DR;
        end
        ST_PA_DR:
        begin
          r_d.st = tms_s ? ST_EX2_DR : ST_PA_DR;
        end
        ST_EX2_DR:
        begin
          r_d.st = tms_s ? ST_UPD_DR : ST_SH_DR;
        end
        ST_UPD_DR:
        begin
          r_d.st = tms_s ? ST_SEL_DR : ST_RTI;
        end

        // Instruction column mirrors the data column
        ST_SEL_IR:
        begin
          r_d.st = tms_s ? ST_TLR : ST_CAP_IR;
        end
        ST_CAP_IR:
        begin
          r_d.st = tms_s ? ST_EX1_IR : ST_SH_IR;
        end
        ST_SH_IR:
        begin
          r_d.st = tms_s ? ST_EX1_IR : ST_SH_IR;
        end
        ST_EX1_IR:
        begin
          r_d.st = tms_s ? ST_UPD_IR : ST_PA_IR;
        end
        ST_PA_IR:
        begin
          r_d.st = tms_s ? ST_EX2_IR : ST_PA_IR;
        end
        ST_EX2_IR:
        begin
          r_d.st = tms_s ? ST_UPD_IR : ST_SH_IR;
        end
        ST_UPD_IR:
        begin
          r_d.st = tms_s ? ST_SEL_DR : ST_RTI;
        end
        default:
        begin
          r_d.st = ST_TLR;
        end
      endcase

      // Held instruction changes only at update, or back to ID at reset
      if (r_q.st == ST_TLR)
      begin
        r_d.instr = BSTP_I_IDCODE; // [RL11]
        r_d.upd[BSTP_OE_CELL] = 1'b0; // [RL22]
      end
      else if (r_q.st == ST_UPD_IR)
      begin
        r_d.instr = ir_sh; // [RL13]
      end

      // Bypass bit clears at capture, then follows the serial input
      if (cap_dr && sel_byp)
      begin
        r_d.byp = 1'b0; // [RL15]
      end
      else if (sh_dr && sel_byp)
      begin
        r_d.byp = tdi_s; // [RL6]
      end

      // Preload latches take the chain at update under sample or extest
      if (r_q.st == ST_UPD_DR &&
          (r_q.instr == BSTP_I_SAMPLE || r_q.instr == BSTP_I_EXTEST))
      begin
        r_d.upd = bsr_sh;
      end
    end

    // Output moves on the falling edge so the far end samples it safely
    // tdo_oe takes the state left by the previous rise
    if (tck_fall)
    begin
      r_d.tdo    = ser_out; // [RL2]
      r_d.tdo_oe = (r_q.st == ST_SH_IR) || (r_q.st == ST_SH_DR); // [RL7]
    end

    // Memory output bus control; a one-cycle lag is far below a tck phase
    case (r_q.instr)
      BSTP_I_EXTEST:
      begin
        r_d.q_en = r_q.upd[BSTP_OE_CELL]; // [RL22]
      end
      BSTP_I_SAMPZ:
      begin
        r_d.q_en = 1'b0; // [RL21]
      end
      default:
      begin
        r_d.q_en = 1'b1;
      end
    endcase
    // Registered so the port output stays glitch free
    r_d.extest = (r_q.instr == BSTP_I_EXTEST);
  end

  // Reset state: controller in reset, output floating, ID selected
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_q.tck_prev <= BSTP_TCK_RST;
      r_q.st       <= ST_TLR;
      r_q.instr    <= BSTP_I_IDCODE; // [RL11]
      r_q.byp      <= 1'b0;
      r_q.tdo      <= 1'b0;
      r_q.tdo_oe   <= 1'b0; // [RL9]
      r_q.upd      <= '0; // [RL22]
      r_q.q_en     <= 1'b1;
      r_q.extest   <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // All outputs straight from the state register
  assign tdo       = r_q.tdo;
  assign tdo_oe    = r_q.tdo_oe;
  assign q_bus_en  = r_q.q_en;
  assign extest_on = r_q.extest;
  assign ring_out  = r_q.upd;

endmodule // bstp_top

//--- bstp_top_properties.sv
/*
  Port checker for the boundary-scan test port, bound into bstp_top.
  Assumes tck is a slow pin that the 100 MHz clk samples.
*/
`timescale 1ns/1ns
module bstp_chk
  import bstp_pkg::*;
(
  input wire logic                              clk,       // System clock
  input wire logic                              rst,       // Sync reset
  input wire logic                              tck,       // Test clock
  input wire logic                              tms,       // Mode select
  input wire logic                              tdi,       // Data in
  input wire logic [bstp_pkg::BSTP_BSR_LEN-1:0] ring_in,   // Pin ring
  input wire logic                              tdo,       // Data out
  input wire logic                              tdo_oe,    // Out enable
  input wire logic                              q_bus_en,  // Bus drive
  input wire logic                              extest_on, // External test
  input wire logic [bstp_pkg::BSTP_BSR_LEN-1:0] ring_out   // Preload cells
);
  logic       tck_q;
  logic [3:0] fall_q;
  logic [3:0] rise_q;

  // Cycles since the last seen tck edge; saturates so idle stays quiet
  always_ff @(posedge clk)
  begin
    tck_q <= tck;
    if (rst)
    begin
      fall_q <= 4'hF;
      rise_q <= 4'hF;
    end
    else
    begin
      fall_q <= (tck_q && !tck) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
      rise_q <= (!tck_q && tck) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hF};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_TDO_FALL: assert property ($changed(tdo) |-> fall_q inside {[3:7]})
    else $error("tdo changed away from a tck fall");
  AST_OE_FALL: assert property ($changed(tdo_oe) |-> fall_q inside {[3:7]})
    else $error("tdo_oe changed away from a tck fall");
  AST_OE_RST: assert property ($fell(rst) |-> !tdo_oe && q_bus_en && !extest_on)
    else $error("outputs wrong right after reset");
  AST_RING_RST: assert property ($fell(rst) |-> !ring_out[BSTP_OE_CELL])
    else $error("control cell not low after reset");
  AST_QBUS_EXT: assert property ((extest_on && $stable(ring_out[BSTP_OE_CELL])) [*3]
    |-> q_bus_en == ring_out[BSTP_OE_CELL])
    else $error("bus enable does not follow control cell");
  AST_QBUS_TCK: assert property ($changed(q_bus_en) |-> rise_q inside {[3:9]})
    else $error("bus enable changed away from a tck rise");
  AST_RING_TCK: assert property ($changed(ring_out) |-> rise_q inside {[3:9]})
    else $error("preload cells changed away from a tck rise");
  AST_EXT_TCK: assert property ($changed(extest_on) |-> rise_q inside {[3:9]})
    else $error("instruction changed away from a tck rise");
endmodule // bstp_chk

bind bstp_top bstp_chk u_chk (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
  .tdi(tdi), .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe),
  .q_bus_en(q_bus_en), .extest_on(extest_on), .ring_out(ring_out));

//--- bstp_ctl_model.sv
/*
  Behavioural scan controller that drives the test pins.
  Assumes clk is the 100 MHz bench clock; one tck period is 8 cycles.
*/
`timescale 1ns/1ns
module bstp_ctl_model (
  input  wire logic clk,    // Bench clock
  input  wire logic tdo,    // Serial data out
  input  wire logic tdo_oe, // Data out enable
  output logic      tck,    // Test clock
  output logic      tms,    // Mode select
  output logic      tdi     // Data in
);
  // Pins idle high through the pull-ups, clock parked low
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // One period: inputs move a cycle after the fall so they hold five
  // cycles past the rise; tdo read late in the high phase, still valid
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge clk);
    tck = 1'h0;
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge clk);
    tck = 1'h1;
    repeat (3) @(negedge clk);
    o = tdo_oe ? tdo : 1'hz;
  endtask

  // Clock stands still low between frames, data in released
  task automatic park();
    @(negedge clk);
    tck = 1'h0;
    tdi = 1'h1;
    repeat (8) @(negedge clk);
  endtask

  // Five rises with tms high, then idle
  task automatic treset();
    logic o;
    repeat (5) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    park();
  endtask

  // Scan from idle through IR or DR path, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'h1, 1'h1, o);
    if (ir)
      step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    park();
  endtask
endmodule // bstp_ctl_model

//--- tb_boundary_scan_test_port.sv
/*
  Self-checking bench for the scan test port against a reference model.
  Assumes the controller model and the bound checker are compiled.
*/
`timescale 1ns/1ns
module tb_boundary_scan_test_port;
  import bstp_pkg::*;
  logic                    clk, rst, tck, tms, tdi, tdo, tdo_oe;
  logic                    q_bus_en, extest_on;
  logic [BSTP_BSR_LEN-1:0] ring_in, ring_out, ring_q;
  logic [127:0]            din, dout;
  logic [2:0]              ir_q;
  logic [2:0]              ring_ops [3];
  int                      n_mismatch, num_checks;

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  bstp_top u_dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe), .q_bus_en(q_bus_en),
    .extest_on(extest_on), .ring_out(ring_out));
  bstp_ctl_model u_ctl (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
    .tms(tms), .tdi(tdi));

  // Compare one result and count it
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Idle outputs predicted from modelled instruction and preload cells
  task automatic chk_pins();
    chk(tdo_oe, 0);
    chk(extest_on, ir_q == BSTP_I_EXTEST);
    chk(q_bus_en, ir_q == BSTP_I_EXTEST ? ring_q[BSTP_OE_CELL] : ir_q != BSTP_I_SAMPZ);
    chk(ring_out, ring_q);
  endtask

  // New instruction; captured pattern reads back first
  task automatic load_ir(input logic [2:0] code);
    din = {125'h0, code};
    u_ctl.scan(1'h1, 3, din, dout);
    ir_q = code;
    chk(dout[2:0], BSTP_IR_CAP);
    chk_pins();
  endtask

  // Data scan with random fill; c sets the bus control cell
  task automatic scan_dr(input int n, input logic c);
    din = {$urandom, $urandom, $urandom, $urandom};
    din[BSTP_OE_CELL] = c;
    u_ctl.scan(1'h0, n, din, dout);
  endtask

  // Ring capture and shift; preload lands except under hi-Z sample
  task automatic ring_scan(input logic c);
    din = {$urandom, $urandom, $urandom, $urandom};
    ring_in = din[BSTP_BSR_LEN-1:0];
    scan_dr(BSTP_BSR_LEN, c);
    chk(dout[BSTP_BSR_LEN-1:0], ring_in);
    if (ir_q != BSTP_I_SAMPZ)
      ring_q = din[BSTP_BSR_LEN-1:0];
    chk_pins();
  endtask

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, n_mismatch);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: a stuck run counts as a mismatch
  initial
  begin
    #900000;
    n_mismatch++;
    conclude();
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    rst = 1'h1;
    ring_in = '0;
    ring_q = '0;
    ir_q = BSTP_I_IDCODE;
    ring_ops = '{BSTP_I_SAMPLE, BSTP_I_EXTEST, BSTP_I_SAMPZ};
    void'($urandom(32'hB7F3E543));
    repeat (12) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    chk_pins();
    done("reset");
    u_ctl.treset();
    scan_dr(BSTP_ID_W, 1'h0);
    chk(dout[31:0], BSTP_IDCODE);
    done("idcode");
    load_ir(BSTP_I_BYPASS);
    scan_dr(8, 1'h0);
    chk(dout[7:0], {din[6:0], 1'h0});
    done("bypass");
    // Each ring instruction with the control cell low then high
    foreach (ring_ops[k])
    begin
      load_ir(ring_ops[k]);
      ring_scan(1'h0);
      ring_scan(1'h1);
      done("ring");
    end
    // Reset through tms clears the control cell and restores the ID instruction
    u_ctl.treset();
    ir_q = BSTP_I_IDCODE;
    ring_q[BSTP_OE_CELL] = 1'h0;
    chk_pins();
    load_ir(BSTP_I_EXTEST);
    done("tms reset");
    conclude();
  end
endmodule // tb_boundary_scan_test_port
